// ### logic/rss_exec.sv
// Execution datapath for rotate, subtract-with-borrow, skip and set ops.
// Assumes a classic Wishbone master on the single 200 MHz clock.
//
// Functional notes
// RQ1 - Rotate left via carry, write memory, carry only
// RQ2 - Same rotate to accumulator, memory untouched
// RQ3 - Plain rotate right, no flags, memory or accumulator
// RQ4 - Rotate right via carry, write memory, carry only
// RQ5 - Same right rotate to accumulator, memory untouched
// RQ6 - Acc plus inverted byte plus carry to accumulator
// RQ7 - Same subtraction and flags, result to memory
// RQ8 - Increment byte, write back, skip on zero
// RQ9 - Taken skip adds one dummy cycle, discards fetch
// RQ10 - Increment to accumulator, skip on zero
// RQ11 - Decrement, memory or accumulator, skip on zero
// RQ12 - Set byte writes all ones, flags kept
// RQ13 - Set bit forces one bit, flags kept
//
// The register addresses and the Wishbone interface to the registers were left to the implementer.
`include "rss_cfg.svh"
`default_nettype none
module rss_exec (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic mem_we,
   output logic [7:0] mem_wdata,
   output logic discard_fetch
);

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      rss_pkg::rss_state_e st;
      logic [3:0] op;
      logic [2:0] bit_sel;
      logic [7:0] opnd;
      logic [7:0] acc;
      logic [3:0] flags;
      logic skip;
      logic [7:0] mem_out;
      logic mem_we;
      logic discard;
      logic [31:0] dat;
      logic ack;
   } rss_state_s;

   rss_state_s s_q;
   rss_state_s s_d;
   rss_pkg::rss_alu_s alu;
   logic [2:0] idx;
   logic hit;
   logic req;
   logic go;

   rss_wb_dec u_dec (
      .adr(wb_adr_i),
      .idx(idx),
      .hit(hit)
   );

   rss_alu u_alu (
      .op(rss_pkg::rss_op_e'(s_q.op)),
      .mem_byte(s_q.opnd),
      .acc(s_q.acc),
      .bit_sel(s_q.bit_sel),
      .flags_in(s_q.flags),
      .out(alu)
   );

   assign req = wb_cyc_i && wb_stb_i && !s_q.ack;
   assign go = req && wb_we_i && hit && (idx == 3'h0) && wb_sel_i[3]
      && wb_dat_i[`RSS_CTRL_GO_BIT] && (s_q.st == rss_pkg::RSS_IDLE);

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      s_d = s_q;
      s_d.ack = req;
      s_d.mem_we = 1'b0;
      s_d.discard = 1'b0;
      // Register reads
      s_d.dat = 32'h0000_0000;
      if (req && !wb_we_i && hit) begin
         unique case (idx)
            3'h0: s_d.dat = {29'h000_0000, s_q.bit_sel} << `RSS_CTRL_BIT_LSB
               | {28'h000_0000, s_q.op};
            3'h1: s_d.dat = {24'h00_0000, s_q.opnd};
            3'h2: s_d.dat = {24'h00_0000, s_q.acc};
            3'h3: s_d.dat = {28'h000_0000, s_q.flags};
            default: s_d.dat = {29'h000_0000, s_q.mem_we, s_q.skip,
               s_q.st != rss_pkg::RSS_IDLE};
         endcase
      end
      // Register writes, only while idle
      if (req && wb_we_i && hit && s_q.st == rss_pkg::RSS_IDLE) begin
         unique case (idx)
            3'h0: begin
               if (wb_sel_i[0]) s_d.op = wb_dat_i[3:0];
               if (wb_sel_i[1]) s_d.bit_sel = wb_dat_i[10:8];
            end
            3'h1: if (wb_sel_i[0]) s_d.opnd = wb_dat_i[7:0];
            3'h2: if (wb_sel_i[0]) s_d.acc = wb_dat_i[7:0];
            3'h3: if (wb_sel_i[0]) s_d.flags = wb_dat_i[3:0];
            default: s_d.skip = 1'b0;
         endcase
      end
      if (go) begin
         if (wb_sel_i[0]) s_d.op = wb_dat_i[3:0];
         if (wb_sel_i[1]) s_d.bit_sel = wb_dat_i[10:8];
         s_d.st = rss_pkg::RSS_EXEC;
      end
      // Execution sequence
      unique case (s_q.st)
         rss_pkg::RSS_IDLE: begin
         end
         rss_pkg::RSS_EXEC: begin
            s_d.flags = (s_q.flags & ~alu.flag_mask) | (alu.flags & alu.flag_mask); // RQ6
            if (alu.wr_acc) s_d.acc = alu.res; // RQ2
            if (alu.wr_mem) begin
               s_d.opnd = alu.res; // RQ7
               s_d.mem_out = alu.res; // RQ1
               s_d.mem_we = 1'b1; // RQ12
            end
            s_d.skip = alu.skip;
            if (alu.skip) begin
               s_d.discard = 1'b1; // RQ9
               s_d.st = rss_pkg::RSS_DUMMY;
            end else begin
               s_d.st = rss_pkg::RSS_IDLE; // RQ9
            end
         end
         rss_pkg::RSS_DUMMY: begin
            s_d.st = rss_pkg::RSS_IDLE; // RQ9
         end
         default: s_d.st = rss_pkg::RSS_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign wb_dat_o = s_q.dat;
   assign wb_ack_o = s_q.ack;
   assign mem_we = s_q.mem_we;
   assign mem_wdata = s_q.mem_out;
   assign discard_fetch = s_q.discard;

endmodule : rss_exec
`default_nettype wire

// ### logic/rss_cfg.svh
// Constants of the rotate, subtract, skip and set execution datapath.
// Assumes a 32-bit classic Wishbone slave with word-aligned registers.
`ifndef RSS_CFG_SVH
`define RSS_CFG_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define RSS_OFF_CTRL 8'h00
`define RSS_OFF_OPND 8'h04
`define RSS_OFF_ACC 8'h08
`define RSS_OFF_FLAGS 8'h0C
`define RSS_OFF_STAT 8'h10

// ----------------------------------------
// Field positions
// ----------------------------------------
`define RSS_CTRL_GO_BIT 31
`define RSS_CTRL_OP_LSB 0
`define RSS_CTRL_BIT_LSB 8
`define RSS_FLG_C 0
`define RSS_FLG_HALF 1
`define RSS_FLG_Z 2
`define RSS_FLG_WRAP 3
`define RSS_ST_BUSY 0
`define RSS_ST_SKIP 1
`define RSS_ST_MWR 2

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define RSS_RST_BYTE 8'h00
`define RSS_RST_FLAGS 4'h0
`define RSS_SKIP_DUMMY_CYC 1

`endif

// ### logic/rss_pkg.sv
// Types shared by the execution datapath files.
// Assumes nothing outside itself.
`default_nettype none
package rss_pkg;

   // ----------------------------------------
   // Operation codes
   // ----------------------------------------
   typedef enum logic [3:0] {
      rotate_left_thru_carry_mem = 4'h0,
      rotate_left_thru_carry_to_work = 4'h1,
      rotate_right_mem = 4'h2,
      rotate_right_to_work = 4'h3,
      rotate_right_thru_carry_mem = 4'h4,
      rotate_right_thru_carry_to_work = 4'h5,
      subtract_with_borrow_to_work = 4'h6,
      subtract_with_borrow_to_mem = 4'h7,
      decrement_skip_on_zero = 4'h8,
      decrement_skip_on_zero_to_work = 4'h9,
      increment_skip_on_zero = 4'hA,
      increment_skip_on_zero_to_work = 4'hB,
      set_byte_mem = 4'hC,
      set_bit_mem = 4'hD
   } rss_op_e;

   typedef enum logic [1:0] {
      RSS_IDLE,
      RSS_EXEC,
      RSS_DUMMY
   } rss_state_e;

   typedef struct packed {
      logic [7:0] res;
      logic wr_mem;
      logic wr_acc;
      logic [3:0] flag_mask;
      logic [3:0] flags;
      logic skip;
   } rss_alu_s;

endpackage : rss_pkg
`default_nettype wire

// ### logic/rss_alu.sv
// Combinational result and flag logic for one instruction.
// Assumes operand, accumulator and flags are stable for the cycle.
`include "rss_cfg.svh"
`default_nettype none
module rss_alu (
   input wire rss_pkg::rss_op_e op,
   input wire logic [7:0] mem_byte,
   input wire logic [7:0] acc,
   input wire logic [2:0] bit_sel,
   input wire logic [3:0] flags_in,
   output rss_pkg::rss_alu_s out
);

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic is_zero(input logic [7:0] v);
      return v == 8'h00;
   endfunction : is_zero

   logic c_in;
   logic [8:0] sum;
   logic [4:0] low;
   logic [7:0] nm;
   logic [7:0] inc_v;
   logic [7:0] dec_v;

   assign c_in = flags_in[`RSS_FLG_C];
   assign nm = ~mem_byte;
   assign sum = {1'b0, acc} + {1'b0, nm} + {8'h00, c_in};
   assign low = {1'b0, acc[3:0]} + {1'b0, nm[3:0]} + {4'h0, c_in};
   assign inc_v = mem_byte + 8'h01;
   assign dec_v = mem_byte - 8'h01;

   // Result, destination and flag selection
   always_comb begin
      out = '0;
      unique case (op)
         rss_pkg::rotate_left_thru_carry_mem, rss_pkg::rotate_left_thru_carry_to_work: begin
            out.res = {mem_byte[6:0], c_in}; // RQ1
            out.flags[`RSS_FLG_C] = mem_byte[7];
            out.flag_mask[`RSS_FLG_C] = 1'b1;
            out.wr_mem = (op == rss_pkg::rotate_left_thru_carry_mem); // RQ1
            out.wr_acc = (op == rss_pkg::rotate_left_thru_carry_to_work); // RQ2
         end
         rss_pkg::rotate_right_mem, rss_pkg::rotate_right_to_work: begin
            out.res = {mem_byte[0], mem_byte[7:1]}; // RQ3
            out.wr_mem = (op == rss_pkg::rotate_right_mem); // RQ3
            out.wr_acc = (op == rss_pkg::rotate_right_to_work); // RQ3
         end
         rss_pkg::rotate_right_thru_carry_mem, rss_pkg::rotate_right_thru_carry_to_work: begin
            out.res = {c_in, mem_byte[7:1]}; // RQ4
            out.flags[`RSS_FLG_C] = mem_byte[0];
            out.flag_mask[`RSS_FLG_C] = 1'b1;
            out.wr_mem = (op == rss_pkg::rotate_right_thru_carry_mem); // RQ4
            out.wr_acc = (op == rss_pkg::rotate_right_thru_carry_to_work); // RQ5
         end
         rss_pkg::subtract_with_borrow_to_work, rss_pkg::subtract_with_borrow_to_mem: begin
            out.res = sum[7:0]; // RQ6
            out.flags[`RSS_FLG_C] = sum[8];
            out.flags[`RSS_FLG_HALF] = low[4];
            out.flags[`RSS_FLG_Z] = is_zero(sum[7:0]);
            out.flags[`RSS_FLG_WRAP] = (acc[7] == nm[7]) && (sum[7] != acc[7]);
            out.flag_mask = 4'hF;
            out.wr_acc = (op == rss_pkg::subtract_with_borrow_to_work); // RQ6
            out.wr_mem = (op == rss_pkg::subtract_with_borrow_to_mem); // RQ7
         end
         rss_pkg::increment_skip_on_zero, rss_pkg::increment_skip_on_zero_to_work: begin
            out.res = inc_v; // RQ8
            out.skip = is_zero(inc_v); // RQ10
            out.wr_mem = (op == rss_pkg::increment_skip_on_zero); // RQ8
            out.wr_acc = (op == rss_pkg::increment_skip_on_zero_to_work); // RQ10
         end
         rss_pkg::decrement_skip_on_zero, rss_pkg::decrement_skip_on_zero_to_work: begin
            out.res = dec_v; // RQ11
            out.skip = is_zero(dec_v); // RQ11
            out.wr_mem = (op == rss_pkg::decrement_skip_on_zero); // RQ11
            out.wr_acc = (op == rss_pkg::decrement_skip_on_zero_to_work); // RQ11
         end
         rss_pkg::set_byte_mem: begin
            out.res = 8'hFF; // RQ12
            out.wr_mem = 1'b1;
         end
         rss_pkg::set_bit_mem: begin
            out.res = mem_byte | (8'h01 << bit_sel); // RQ13
            out.wr_mem = 1'b1;
         end
         default: begin
            out = '0;
         end
      endcase
   end

endmodule : rss_alu
`default_nettype wire

// ### logic/rss_wb_dec.sv
// Wishbone address decode for the register file.
// Assumes word-aligned byte addresses on an 8-bit offset.
`include "rss_cfg.svh"
`default_nettype none
module rss_wb_dec (
   input wire logic [7:0] adr,
   output logic [2:0] idx,
   output logic hit
);

   // Offset to register index
   always_comb begin
      hit = 1'b1;
      idx = 3'h0;
      unique case (adr)
         `RSS_OFF_CTRL: idx = 3'h0;
         `RSS_OFF_OPND: idx = 3'h1;
         `RSS_OFF_ACC: idx = 3'h2;
         `RSS_OFF_FLAGS: idx = 3'h3;
         `RSS_OFF_STAT: idx = 3'h4;
         default: hit = 1'b0;
      endcase
   end

endmodule : rss_wb_dec
`default_nettype wire

// ### tb/rss_exec_monitor.sv
// Port checker of the execution datapath.
// Assumes it is bound to rss_exec on one clock.
`default_nettype none
module rss_exec_monitor (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic mem_we,
   input wire logic [7:0] mem_wdata,
   input wire logic discard_fetch
);
   logic go;
   logic [3:0] age_q;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   // Start of an operation as it is accepted
   assign go = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[3]
      && wb_adr_i == 8'h00 && wb_dat_i[31];
   // Cycles since the last start, saturating
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) age_q <= 4'hF;
      else if (go) age_q <= 4'h0;
      else if (age_q != 4'hF) age_q <= age_q + 4'h1;
   end
   ack_one_cycle_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack late");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
   wr_pulse_a: assert property (mem_we |=> !mem_we) else $error("write held");
   drop_pulse_a:
      assert property (discard_fetch |=> !discard_fetch) else $error("drop held");
   drop_cause_a:
      assert property (discard_fetch |-> age_q == 4'h0) else $error("stray drop");
   wdata_hold_a: assert property ($changed(mem_wdata) |-> mem_we) else $error("data moved");
   set_byte_a:
      assert property (go && wb_dat_i[3:0] == 4'hC |-> ##[1:3] mem_we && mem_wdata == 8'hFF)
      else $error("set byte lost");
   work_dest_a:
      assert property (go && wb_dat_i[3:0] inside {4'h1, 4'h3, 4'h5, 4'h6, 4'h9, 4'hB}
      |=> !mem_we [*3]) else $error("memory touched");
   no_skip_a:
      assert property (go && wb_dat_i[3:0] < 4'h8 |=> !discard_fetch [*3])
      else $error("drop without skip");
   cover property (go);
   cover property (mem_we);
   cover property (discard_fetch);
endmodule : rss_exec_monitor
bind rss_exec rss_exec_monitor i_rss_exec_monitor (.clock, .rst_b, .wb_cyc_i, .wb_stb_i,
   .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .mem_we, .mem_wdata,
   .discard_fetch);
`default_nettype wire

// ### tb/rss_fetch_model.sv
// Fetch side model: keeps the data byte and counts writes and drops.
// Assumes one-cycle registered pulses from the datapath.
`default_nettype none
module rss_fetch_model (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic mem_we,
   input wire logic [7:0] mem_wdata,
   input wire logic discard_fetch,
   output logic [7:0] mem_q,
   output logic [7:0] n_wr,
   output logic [7:0] n_drop
);
   // Take write-backs and count each dropped fetch on a skip
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         mem_q <= 8'h00;
         n_wr <= 8'h00;
         n_drop <= 8'h00;
      end else begin
         if (mem_we) mem_q <= mem_wdata;
         if (mem_we) n_wr <= n_wr + 8'h01;
         if (discard_fetch) n_drop <= n_drop + 8'h01;
      end
   end
endmodule : rss_fetch_model
`default_nettype wire

// ### tb/rss_exec_tb.sv
// Bench of the execution datapath over its register bus.
// Assumes the datapath, fetch model and checker are compiled first.
`default_nettype none
module rss_exec_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o, mem_we, discard_fetch;
   logic [7:0] mem_wdata, mq, nwr, ndrop;
   logic [7:0] tm [3] = '{8'h01, 8'hFF, 8'h96};
   logic [7:0] ta [3] = '{8'h01, 8'h3C, 8'h7F};
   logic [3:0] tf [3] = '{4'h1, 4'h0, 4'hB};
   int n_errors = 0;
   int n_checks = 0;
   rss_exec i_rss_exec (.clock, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
      .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .mem_we, .mem_wdata, .discard_fetch);
   rss_fetch_model i_rss_fetch_model (.clock, .rst_b, .mem_we, .mem_wdata, .discard_fetch,
      .mem_q(mq), .n_wr(nwr), .n_drop(ndrop));
   // Clock at 200 MHz
   initial forever #2.5 clock = ~clock;
   task automatic stop_test;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : stop_test
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // One classic cycle, held until ack
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
      int k;
      @(posedge clock);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_sel_i <= 4'hF;
      wb_dat_i <= d;
      k = 0;
      do begin
         @(posedge clock);
         k++;
      end while (wb_ack_o !== 1'b1 && k < 50);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (wb_ack_o !== 1'b1) begin
         n_errors++;
         stop_test();
      end
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr
   // Expected {mem write, skip, flags, acc, byte}
   function automatic logic [21:0] model(input logic [3:0] op, input logic [7:0] m, a,
      input logic [3:0] f, input logic [2:0] b);
      logic [8:0] s;
      logic [4:0] h;
      logic [7:0] ac, me, n, r;
      logic [3:0] fl;
      logic wm, sk;
      n = ~m;
      s = {1'b0, a} + {1'b0, n} + {8'h00, f[0]};
      h = {1'b0, a[3:0]} + {1'b0, n[3:0]} + {4'h0, f[0]};
      ac = a;
      me = m;
      fl = f;
      wm = op inside {4'h0, 4'h2, 4'h4, 4'h7, 4'h8, 4'hA, 4'hC, 4'hD};
      case (op)
         4'h0, 4'h1: {fl[0], r} = {m, f[0]};
         4'h2, 4'h3: r = {m[0], m[7:1]};
         4'h4, 4'h5: {r, fl[0]} = {f[0], m};
         4'h6, 4'h7: begin
            r = s[7:0];
            fl = {a[7] == n[7] && r[7] != a[7], r == 8'h00, h[4], s[8]};
         end
         4'h8, 4'h9: r = m - 8'h01;
         4'hA, 4'hB: r = m + 8'h01;
         4'hC: r = 8'hFF;
         default: r = m | (8'h01 << b);
      endcase
      sk = op > 4'h7 && op < 4'hC && r == 8'h00;
      if (wm) me = r;
      else ac = r;
      return {wm, sk, fl, ac, me};
   endfunction : model
   // Every operation on three operand sets
   initial begin
      logic [31:0] q;
      logic [21:0] e;
      logic [7:0] w0, d0;
      int k;
      repeat (6) @(posedge clock);
      rst_b <= 1'b1;
      wr(8'h14, 32'hFF);
      bus(1'b0, 8'h14, 32'h0, q);
      check(q[7:0], 8'h00);
      for (int op = 0; op < 14; op++) begin
         for (int j = 0; j < 3; j++) begin
            e = model(4'(op), tm[j], ta[j], tf[j], 3'(j * 3));
            w0 = nwr;
            d0 = ndrop;
            wr(8'h04, {24'h0, tm[j]});
            wr(8'h08, {24'h0, ta[j]});
            wr(8'h0C, {28'h0, tf[j]});
            wr(8'h00, {1'b1, 20'h0, 3'(j * 3), 4'h0, 4'(op)});
            k = 0;
            do begin
               bus(1'b0, 8'h10, 32'h0, q);
               k++;
            end while (q[0] !== 1'b0 && k < 20);
            // A datapath still busy after the poll limit ends the run
            if (q[0] !== 1'b0) begin
               n_errors++;
               stop_test();
            end
            check({7'h0, q[1]}, {7'h0, e[20]});
            bus(1'b0, 8'h08, 32'h0, q);
            check(q[7:0], e[15:8]);
            bus(1'b0, 8'h04, 32'h0, q);
            check(q[7:0], e[7:0]);
            bus(1'b0, 8'h0C, 32'h0, q);
            check({4'h0, q[3:0]}, {4'h0, e[19:16]});
            check(nwr - w0, {7'h0, e[21]});
            check(ndrop - d0, {7'h0, e[20]});
            if (e[21]) check(mq, e[7:0]);
            wr(8'h10, 32'h0);
         end
      end
      stop_test();
   end
endmodule : rss_exec_tb
`default_nettype wire
